/* File: rtl/mrb_pkg.sv */
// constants for the mode-register behaviour block
// assumes: single 100 MHz clock, command pins synchronous to it
package mrb_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned PIPE_W = 32;
  // bank codes of mode register set
  localparam logic [2:0] BA_SECOND = 3'h1;
  localparam logic [2:0] BA_THIRD = 3'h2;
  localparam logic [2:0] BA_FOURTH = 3'h3;
  // second mode register fields
  localparam int unsigned M1_DLL_OFF = 0;
  localparam int unsigned M1_RTT0 = 2;
  localparam int unsigned M1_AL_LO = 3;
  localparam int unsigned M1_RTT1 = 6;
  localparam int unsigned M1_WLEV = 7;
  localparam int unsigned M1_RTT2 = 9;
  localparam int unsigned M1_QOFF = 12;
  // third mode register fields
  localparam int unsigned M2_PARTIAL_ARRAY_RETENTION_LO = 0;
  localparam int unsigned M2_CWL_LO = 3;
  localparam int unsigned M2_ASR = 6;
  localparam int unsigned M2_SRT = 7;
  localparam int unsigned M2_RTTWR_LO = 9;
  // fourth mode register fields
  localparam int unsigned M3_LOC_LO = 0;
  localparam int unsigned M3_PAT_EN = 2;
  // additive latency codes
  localparam logic [1:0] AL_ZERO = 2'h0;
  localparam logic [1:0] AL_CL_M1 = 2'h1;
  localparam logic [1:0] AL_CL_M2 = 2'h2;
  // latencies
  localparam logic [4:0] CWL_BASE = 5'h05;
  localparam logic [3:0] CL_RESET = 4'h6;
  localparam logic [4:0] DLL_OFF_LAT = 5'h06;
  localparam logic [2:0] BURST_CLKS = 3'h4;
  // register map, byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MR_SECOND = 8'h04;
  localparam logic [7:0] OFS_MR_THIRD = 8'h08;
  localparam logic [7:0] OFS_MR_FOURTH = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : mrb_pkg

/* File: rtl/mrb_top.sv */
// mode-register driven latency, termination and readout control
// assumes: command pins sampled on MCLK, AXI4-Lite master on MCLK,
// column read delay given by software through the control register
//
// Contract
// RULE1 - additive code 00 zero, 01 read delay-1, 10 read delay-2, 11 reserved
// RULE2 - accept read/write right after activate, execute after additive delay
// RULE3 - total read delay is additive plus column read delay
// RULE4 - total write delay is additive plus column write delay
// RULE5 - column write delay from third register bits 5:3, whole cycles
// RULE6 - second register bit 12 disconnects data and strobe outputs
// RULE7 - write termination applies during writes even without nominal one
// RULE8 - third register bits 10:9 set dynamic termination, off in leveling
// RULE9 - mode set with bank 2 loads third register from address pins
// RULE10 - mode set with bank 3 loads fourth register from address pins
// RULE11 - controller zeroes bank bit 2 and bits 8, 14:11 for third
// RULE12 - controller zeroes bank bit 2 and bits 14:3 for fourth
// RULE13 - fourth register bits 1:0 ignored while bit 2 is zero
// RULE14 - controller sets fourth register bit 2 with banks precharged
// RULE15 - pattern readout answers every read from the pattern register
// RULE16 - controller issues only reads while pattern readout is on; the model also lets mode register sets through
// RULE17 - self refresh rate from bit 7 unless automatic mode uses sensor
// RULE18 - partial retention drops outer data once self refresh entered
// RULE19 - no-operation and deselect register nothing, work continues
// RULE20 - second register bit 0 disables the DLL until written zero
// RULE21 - DLL off supports only column read and write delay of six
// RULE22 - DLL off read strobe one cycle earlier than total read delay
// RULE23 - mode set with bank 1 loads second register from address pins
// RULE24 - each mode register holds its value until addressed again
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
module mrb_top
  import mrb_pkg::*;
(
  input wire logic MCLK, // device clock
  input wire logic RST_N, // async reset, active low
  input wire logic CKE, // clock enable pin
  input wire logic CS_N, // chip select, active low
  input wire logic RAS_N, // row strobe, active low
  input wire logic CAS_N, // column strobe, active low
  input wire logic WE_N, // write enable, active low
  input wire logic [2:0] BA, // bank address
  input wire logic [14:0] A, // address pins
  input wire logic TEMP_HOT, // on-die sensor, asynchronous
  output logic INT_READ, // internal read execution pulse
  output logic INT_WRITE, // internal write execution pulse
  output logic READ_DATA_START, // first read data cycle pulse
  output logic WRITE_DATA_START, // first write data cycle pulse
  output logic READ_FROM_PATTERN, // reads served from pattern register
  output logic [1:0] PATTERN_SEL, // pattern location, zero when off
  output logic OUTPUTS_OFF, // data and strobe drivers disconnected
  output logic [2:0] RTT_NOM_SEL, // nominal termination code
  output logic ODT_WR_ACTIVE, // write termination applied now
  output logic [1:0] RTT_WR_SEL, // write termination code
  output logic WRITE_LEVELING, // write leveling mode
  output logic DLL_DISABLED, // DLL off mode
  output logic SR_RATE_EXT, // extended self refresh rate
  output logic SELF_REFRESH, // device in self refresh
  output logic RETAIN_LIMITED, // data outside range not retained
  output logic [2:0] PARTIAL_ARRAY_RETENTION_RANGE, // partial retention range code
  input wire logic [7:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // write strobes
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [7:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY // read data ready
);

  typedef struct packed {
    logic [ADDR_W-1:0] mr_second;
    logic [ADDR_W-1:0] mr_third;
    logic [ADDR_W-1:0] mr_fourth;
    logic [3:0] col_rd;
    logic [PIPE_W-1:0] rd_pipe;
    logic [PIPE_W-1:0] wr_pipe;
    logic [PIPE_W-1:0] ird_pipe;
    logic [PIPE_W-1:0] iwr_pipe;
    logic [2:0] wr_win;
    logic sref;
    logic [2:0] hot_sync;
    logic hot;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } mrb_state_s;

  mrb_state_s st_q;
  mrb_state_s st_d;
  logic rst_m_q;
  logic rst_s_q;

  // reset release through two flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // command decode
  logic sel;
  logic cmd_mrs;
  logic cmd_rd;
  logic cmd_wr;
  logic cmd_ref;
  logic cmd_nop;
  assign sel = !CS_N && CKE && !st_q.sref;
  assign cmd_mrs = sel && !RAS_N && !CAS_N && !WE_N;
  assign cmd_rd = sel && RAS_N && !CAS_N && WE_N;
  assign cmd_wr = sel && RAS_N && !CAS_N && !WE_N;
  assign cmd_ref = !CS_N && !RAS_N && !CAS_N && WE_N;
  assign cmd_nop = CS_N || (RAS_N && CAS_N && WE_N);

  // latency arithmetic
  logic [1:0] al_code;
  logic [4:0] cl5;
  logic [4:0] al;
  logic [4:0] column_write_delay;
  logic [4:0] rl_full;
  logic [4:0] rl_eff;
  logic [4:0] wl;
  logic dll_off;
  always_comb begin
    al_code = st_q.mr_second[M1_AL_LO +: 2];
    cl5 = {1'b0, st_q.col_rd};
    dll_off = st_q.mr_second[M1_DLL_OFF]; // RULE20
    unique case (al_code) // RULE1
      AL_CL_M1: al = cl5 - 5'h01;
      AL_CL_M2: al = cl5 - 5'h02;
      default: al = 5'h00;
    endcase
    column_write_delay = CWL_BASE + {2'h0, st_q.mr_third[M2_CWL_LO +: 3]}; // RULE5
    rl_full = al + cl5; // RULE3
    rl_eff = dll_off ? rl_full - 5'h01 : rl_full; // RULE22
    if (rl_eff == 5'h00) begin
      rl_eff = 5'h01;
    end
    wl = al + column_write_delay; // RULE4
    if (wl == 5'h00) begin
      wl = 5'h01;
    end
  end

  // only the six/six setting is promised with the DLL off
  logic dll_cfg_bad;
  assign dll_cfg_bad = dll_off &&
    ((cl5 != DLL_OFF_LAT) || (column_write_delay != DLL_OFF_LAT)); // RULE21

  function automatic logic [PIPE_W-1:0] mark(input logic [4:0] lat);
    mark = {{(PIPE_W-1){1'b0}}, 1'b1} << (lat - 5'h01);
  endfunction : mark

  function automatic logic [PIPE_W-1:0] shr(input logic [PIPE_W-1:0] p);
    shr = {1'b0, p[PIPE_W-1:1]};
  endfunction : shr

  // next-state logic
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [31:0] ctrl_word;
  always_comb begin
    st_d = st_q;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    ctrl_word = {28'h0000000, st_q.col_rd};
    // mode register loads; otherwise held, nop/deselect change nothing
    if (cmd_mrs) begin // RULE24 RULE19
      unique case (BA)
        BA_SECOND: st_d.mr_second = A; // RULE23
        BA_THIRD: st_d.mr_third = A; // RULE9
        BA_FOURTH: st_d.mr_fourth = A; // RULE10
        default: ;
      endcase
    end
    // commands taken at once, executed after the additive delay
    st_d.ird_pipe = shr(st_q.ird_pipe);
    st_d.iwr_pipe = shr(st_q.iwr_pipe);
    st_d.rd_pipe = shr(st_q.rd_pipe);
    st_d.wr_pipe = shr(st_q.wr_pipe);
    if (cmd_rd) begin // RULE2
      st_d.rd_pipe = st_d.rd_pipe | mark(rl_eff); // RULE3 RULE22
      if (al != 5'h00) begin
        st_d.ird_pipe = st_d.ird_pipe | mark(al);
      end
    end
    if (cmd_wr) begin // RULE2
      st_d.wr_pipe = st_d.wr_pipe | mark(wl); // RULE4
      if (al != 5'h00) begin
        st_d.iwr_pipe = st_d.iwr_pipe | mark(al);
      end
    end
    // write data window for write termination
    if (st_q.wr_pipe[0]) begin
      st_d.wr_win = BURST_CLKS;
    end else if (st_q.wr_win != 3'h0) begin
      st_d.wr_win = st_q.wr_win - 3'h1;
    end
    // self refresh entry and exit
    if (cmd_ref && !CKE && !st_q.sref) begin
      st_d.sref = 1'b1;
    end else if (CKE && st_q.sref) begin
      st_d.sref = 1'b0;
    end
    // sensor input: counted once second and third stages agree
    st_d.hot_sync = {st_q.hot_sync[1:0], TEMP_HOT};
    if (st_q.hot_sync[1] == st_q.hot_sync[2]) begin
      st_d.hot = st_q.hot_sync[2];
    end
    // AXI write channels, taken in either order
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      st_d.aw_got = 1'b1;
      st_d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      st_d.w_got = 1'b1;
      st_d.w_data = S_AXI_WDATA;
      st_d.w_strb = S_AXI_WSTRB;
    end
    if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
      wr_hit = 1'b1;
      st_d.aw_got = 1'b0;
      st_d.w_got = 1'b0;
      st_d.bvalid = 1'b1;
      unique case ({st_q.aw_addr[7:2], 2'h0})
        OFS_CTRL: begin
          st_d.bresp = RESP_OKAY;
          if (st_q.w_strb[0]) begin
            st_d.col_rd = st_q.w_data[3:0];
          end
        end
        OFS_MR_SECOND, OFS_MR_THIRD, OFS_MR_FOURTH, OFS_STATUS:
          st_d.bresp = RESP_SLVERR;
        default: st_d.bresp = RESP_DECERR;
      endcase
    end
    if (st_q.bvalid && S_AXI_BREADY) begin
      st_d.bvalid = 1'b0;
    end
    // AXI read channel
    rd_word = 32'h00000000;
    st_d.rresp = st_q.rresp;
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rd_hit = 1'b1;
      st_d.rvalid = 1'b1;
      st_d.rresp = RESP_OKAY;
      unique case ({S_AXI_ARADDR[7:2], 2'h0})
        OFS_CTRL: rd_word = ctrl_word;
        OFS_MR_SECOND: rd_word = {17'h00000, st_q.mr_second};
        OFS_MR_THIRD: rd_word = {17'h00000, st_q.mr_third};
        OFS_MR_FOURTH: rd_word = {17'h00000, st_q.mr_fourth};
        OFS_STATUS: rd_word = {10'h000, wl, rl_eff, al, 2'h0,
          dll_cfg_bad, st_q.hot, st_q.sref, st_q.mr_fourth[M3_PAT_EN],
          dll_off};
        default: st_d.rresp = RESP_DECERR;
      endcase
      st_d.rdata = rd_word;
    end else if (st_q.rvalid && S_AXI_RREADY) begin
      st_d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge rst_s_q) begin
    if (!rst_s_q) begin
      st_q <= '0;
      st_q.col_rd <= CL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  logic pat_en;
  logic dyn_en;
  assign pat_en = st_q.mr_fourth[M3_PAT_EN];
  assign dyn_en = st_q.mr_third[M2_RTTWR_LO +: 2] != 2'h0;
  assign INT_READ = (al == 5'h00) ? cmd_rd : st_q.ird_pipe[0]; // RULE2
  assign INT_WRITE = (al == 5'h00) ? cmd_wr : st_q.iwr_pipe[0]; // RULE2
  assign READ_DATA_START = st_q.rd_pipe[0];
  assign WRITE_DATA_START = st_q.wr_pipe[0];
  assign READ_FROM_PATTERN = pat_en; // RULE15
  assign PATTERN_SEL = pat_en ? st_q.mr_fourth[M3_LOC_LO +: 2]
    : 2'h0; // RULE13
  assign OUTPUTS_OFF = st_q.mr_second[M1_QOFF]; // RULE6
  assign RTT_NOM_SEL = {st_q.mr_second[M1_RTT2], st_q.mr_second[M1_RTT1],
    st_q.mr_second[M1_RTT0]};
  assign WRITE_LEVELING = st_q.mr_second[M1_WLEV];
  assign RTT_WR_SEL = WRITE_LEVELING ? 2'h0
    : st_q.mr_third[M2_RTTWR_LO +: 2]; // RULE8
  // independent of the nominal termination code
  assign ODT_WR_ACTIVE = dyn_en && !WRITE_LEVELING
    && (st_q.wr_win != 3'h0); // RULE7 RULE8
  assign DLL_DISABLED = dll_off; // RULE20
  assign SR_RATE_EXT = st_q.mr_third[M2_ASR] ? st_q.hot
    : st_q.mr_third[M2_SRT]; // RULE17
  assign SELF_REFRESH = st_q.sref;
  assign PARTIAL_ARRAY_RETENTION_RANGE = st_q.mr_third[M2_PARTIAL_ARRAY_RETENTION_LO +: 3];
  assign RETAIN_LIMITED = st_q.sref && (PARTIAL_ARRAY_RETENTION_RANGE != 3'h0); // RULE18
  assign S_AXI_AWREADY = !st_q.aw_got && !st_q.bvalid;
  assign S_AXI_WREADY = !st_q.w_got && !st_q.bvalid;
  assign S_AXI_BVALID = st_q.bvalid;
  assign S_AXI_BRESP = st_q.bresp;
  assign S_AXI_ARREADY = !st_q.rvalid;
  assign S_AXI_RVALID = st_q.rvalid;
  assign S_AXI_RDATA = st_q.rdata;
  assign S_AXI_RRESP = st_q.rresp;

  // checks
  a_third_load: assert property (@(posedge MCLK) // RULE9
    disable iff (!rst_s_q)
    cmd_mrs && BA == BA_THIRD |=> st_q.mr_third == $past(A))
    else $error("third mode register not loaded");
  a_fourth_load: assert property (@(posedge MCLK) // RULE10
    disable iff (!rst_s_q)
    cmd_mrs && BA == BA_FOURTH |=> st_q.mr_fourth == $past(A))
    else $error("fourth mode register not loaded");
  a_second_load: assert property (@(posedge MCLK) // RULE23
    disable iff (!rst_s_q)
    cmd_mrs && BA == BA_SECOND |=> st_q.mr_second == $past(A))
    else $error("second mode register not loaded");
  a_nop_holds: assert property (@(posedge MCLK) // RULE19
    disable iff (!rst_s_q)
    cmd_nop |=> $stable(st_q.mr_second) && $stable(st_q.mr_third)
    && $stable(st_q.mr_fourth))
    else $error("mode register changed on nop");
  a_read_six: assert property (@(posedge MCLK) // RULE3
    disable iff (!rst_s_q)
    cmd_rd && rl_eff == 5'h06 |-> ##6 READ_DATA_START)
    else $error("read data not at total read delay");
  a_dll_off_read: assert property (@(posedge MCLK) // RULE22
    disable iff (!rst_s_q)
    cmd_rd && dll_off && al == 5'h00 && cl5 == DLL_OFF_LAT
    |-> ##5 READ_DATA_START)
    else $error("dll off read strobe not one cycle early");
  a_write_five: assert property (@(posedge MCLK) // RULE4
    disable iff (!rst_s_q)
    cmd_wr && wl == 5'h05 |-> ##5 WRITE_DATA_START)
    else $error("write data not at total write delay");
  a_al_one: assert property (@(posedge MCLK) // RULE1
    disable iff (!rst_s_q)
    cmd_rd && al_code == AL_CL_M1 && cl5 == 5'h06
    |-> !INT_READ ##5 INT_READ)
    else $error("additive delay wrong");
  a_out_off: assert property (@(posedge MCLK) // RULE6
    disable iff (!rst_s_q)
    cmd_mrs && BA == BA_SECOND |=> OUTPUTS_OFF == $past(A[M1_QOFF]))
    else $error("outputs not disconnected");
  a_wlev_nodyn: assert property (@(posedge MCLK) // RULE8
    disable iff (!rst_s_q)
    WRITE_LEVELING |-> !ODT_WR_ACTIVE && RTT_WR_SEL == 2'h0)
    else $error("dynamic termination during leveling");
  a_wr_term: assert property (@(posedge MCLK) // RULE7
    disable iff (!rst_s_q)
    WRITE_DATA_START && dyn_en && !WRITE_LEVELING
    |=> ODT_WR_ACTIVE [*4])
    else $error("write termination window wrong");
  a_pat_ignore: assert property (@(posedge MCLK) // RULE13
    disable iff (!rst_s_q)
    cmd_mrs && BA == BA_FOURTH && !A[M3_PAT_EN]
    |=> PATTERN_SEL == 2'h0 && !READ_FROM_PATTERN)
    else $error("pattern bits not ignored");
  a_wr_resp: assert property (@(posedge MCLK) disable iff (!rst_s_q)
    wr_hit |=> S_AXI_BVALID)
    else $error("write response missing");
  a_rd_resp: assert property (@(posedge MCLK) disable iff (!rst_s_q)
    rd_hit |=> S_AXI_RVALID && S_AXI_RDATA == $past(rd_word))
    else $error("read response wrong");
  a_axi_bresp: assert property (@(posedge MCLK) disable iff (!rst_s_q)
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
    |-> ##2 S_AXI_BVALID)
    else $error("write response late");

endmodule : mrb_top

/* File: bench/mrb_ctl_model.sv */
// controller-side model that drives the command and address pins
// assumes: tasks are called from the bench; pins are sampled on MCLK
module mrb_ctl_model
  import mrb_pkg::*;
(
  input wire logic MCLK, // device clock
  output logic CKE, // clock enable
  output logic CS_N, // chip select, active low
  output logic RAS_N, // row strobe, active low
  output logic CAS_N, // column strobe, active low
  output logic WE_N, // write enable, active low
  output logic [2:0] BA, // bank address
  output logic [14:0] A // address pins
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pat_on = 1'h0;
  logic dll_off = 1'h0;
  initial {CKE, CS_N, RAS_N, CAS_N, WE_N, BA, A} = {5'h1f, 18'h0};
  task automatic cmd(input logic [3:0] c, input logic [2:0] b,
    input logic [14:0] a);
    if (pat_on && c != 4'h5 && c != 4'h0) return;
    @(posedge MCLK);
    {CS_N, RAS_N, CAS_N, WE_N} <= c;
    BA <= b;
    A <= a;
    @(posedge MCLK);
    // deselect, and address lines no longer hold the old value
    {CS_N, RAS_N, CAS_N, WE_N} <= 4'hf;
    A <= ~a;
    BA <= ~b;
    // let the loaded state settle before callers look at outputs
    #1;
  endtask : cmd
  task automatic mrs(input logic [2:0] b, input logic [14:0] a);
    logic [14:0] v;
    v = a;
    if (b == BA_THIRD) v = a & 15'h06ff;
    if (b == BA_THIRD && dll_off) v[5:3] = 3'h1;
    if (b == BA_FOURTH) v = a & 15'h0007;
    if (b == BA_FOURTH) cmd(4'h2, 3'h0, 15'h0400);
    if (b == BA_SECOND) dll_off = v[0];
    cmd(4'h0, b, v);
    if (b == BA_FOURTH) pat_on = v[2];
  endtask : mrs
  task automatic sr(input logic on);
    if (pat_on) return;
    @(posedge MCLK);
    CKE <= ~on;
    if (on) {CS_N, RAS_N, CAS_N, WE_N} <= 4'h1;
    @(posedge MCLK);
    {CS_N, RAS_N, CAS_N, WE_N} <= 4'hf;
  endtask : sr
endmodule : mrb_ctl_model

/* File: bench/dram_mode_register_behaviour_tb.sv */
// self-checking bench: command sequences through the controller model,
// registers read back over AXI4-Lite
// assumes: mrb_top and mrb_ctl_model compiled before this file
module dram_mode_register_behaviour_tb;
  import mrb_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic MCLK = 1'h0, RST_N = 1'h0, temp_hot = 1'h0;
  logic cke, cs_n, ras_n, cas_n, we_n;
  logic [2:0] ba;
  logic [14:0] a;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, pat_sel, rttwr, r;
  logic int_rd, int_wr, rd_st, wr_st, rd_pat, outs_off, odt_wr, wlev;
  logic dll_dis, sr_ext, self_ref, ret_lim;
  logic [2:0] rttnom, ret_rng;
  int err_total = 0, n_checks = 0, n, add_d;
  always #5 MCLK = ~MCLK;
  mrb_ctl_model ctl_u (.MCLK(MCLK), .CKE(cke), .CS_N(cs_n), .RAS_N(ras_n),
    .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .A(a));
  mrb_top dut_u (.MCLK(MCLK), .RST_N(RST_N), .CKE(cke), .CS_N(cs_n),
    .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BA(ba), .A(a),
    .TEMP_HOT(temp_hot), .INT_READ(int_rd), .INT_WRITE(int_wr),
    .READ_DATA_START(rd_st), .WRITE_DATA_START(wr_st),
    .READ_FROM_PATTERN(rd_pat), .PATTERN_SEL(pat_sel),
    .OUTPUTS_OFF(outs_off), .RTT_NOM_SEL(rttnom), .ODT_WR_ACTIVE(odt_wr),
    .RTT_WR_SEL(rttwr), .WRITE_LEVELING(wlev), .DLL_DISABLED(dll_dis),
    .SR_RATE_EXT(sr_ext), .SELF_REFRESH(self_ref),
    .RETAIN_LIMITED(ret_lim), .PARTIAL_ARRAY_RETENTION_RANGE(ret_rng),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  task automatic report_and_stop;
    if (err_total == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_lat(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      err_total++;
      $display("MISMATCH %0t delay %0d expected %0d", $time, got, exp);
    end
  endtask : chk_lat
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d,
    output logic [1:0] rs);
    @(posedge MCLK);
    {awaddr, wdata, awvalid, wvalid, bready} <= {ad, d, 3'h7};
    do begin
      @(posedge MCLK);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    rs = bresp;
    bready <= 1'h0;
  endtask : axi_wr
  task automatic rd_chk(input logic [7:0] ad, input logic [31:0] e,
    input logic [1:0] er);
    @(posedge MCLK);
    {araddr, arvalid, rready} <= {ad, 2'h3};
    do begin
      @(posedge MCLK);
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    if (ad == OFS_STATUS) chk_val({17'h0, rdata[21:7]}, e);
    else chk_val(rdata, e);
    chk_val({30'h0, rresp}, {30'h0, er});
  endtask : rd_chk
  // cycle, command cycle being 0, in which the selected output stands
  task automatic lat(input int sel, output int k);
    k = -1;
    for (int i = 1; i <= 40 && k < 0; i++) begin
      #1;
      if ((sel == 0 && rd_st === 1'h1) || (sel == 1 && wr_st === 1'h1) ||
        (sel == 2 && int_rd === 1'h1) || (sel == 3 && int_wr === 1'h1))
        k = i;
      if (k < 0) @(posedge MCLK);
    end
  endtask : lat
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge MCLK);
    RST_N <= 1'h1;
    repeat (3) @(posedge MCLK);
    rd_chk(OFS_CTRL, 32'h6, RESP_OKAY);
    rd_chk(OFS_MR_FOURTH, 32'h0, RESP_OKAY);
    for (int c = 0; c < 4; c++) begin
      ctl_u.mrs(BA_SECOND, 15'(c << 3));
      ctl_u.mrs(BA_THIRD, 15'(c << 3));
      add_d = (c == 1) ? 5 : (c == 2) ? 4 : 0;
      rd_chk(OFS_MR_SECOND, 32'(c << 3), RESP_OKAY);
      rd_chk(OFS_MR_THIRD, 32'(c << 3), RESP_OKAY);
      rd_chk(OFS_STATUS, {17'h0, 5'(add_d + c + 5), 5'(add_d + 6),
        5'(add_d)}, RESP_OKAY);
      ctl_u.cmd(4'h3, 3'h0, 15'h0);
      ctl_u.cmd(4'h5, 3'h0, 15'h0);
      lat(0, n);
      chk_lat(n, add_d + 6);
      ctl_u.cmd(4'h4, 3'h0, 15'h0);
      lat(1, n);
      chk_lat(n, add_d + c + 5);
      ctl_u.cmd(4'h5, 3'h0, 15'h0);
      if (add_d > 0) lat(2, n);
      if (add_d > 0) chk_lat(n, add_d);
      ctl_u.cmd(4'h4, 3'h0, 15'h0);
      if (add_d > 0) lat(3, n);
      if (add_d > 0) chk_lat(n, add_d);
      repeat (12) @(posedge MCLK);
    end
    ctl_u.mrs(BA_SECOND, 15'h1000);
    chk_bit(outs_off, 1'h1);
    ctl_u.cmd(4'h8, BA_SECOND, 15'h0);
    ctl_u.cmd(4'h7, BA_SECOND, 15'h0);
    ctl_u.cmd(4'h0, 3'h0, 15'h0);
    chk_bit(outs_off, 1'h1);
    ctl_u.mrs(BA_SECOND, 15'h0);
    chk_bit(outs_off, 1'h0);
    ctl_u.mrs(BA_THIRD, 15'h0208);
    chk_val({30'h0, rttwr}, 32'h1);
    ctl_u.cmd(4'h4, 3'h0, 15'h0);
    lat(1, n);
    @(posedge MCLK);
    #1;
    chk_bit(odt_wr, 1'h1);
    repeat (4) @(posedge MCLK);
    ctl_u.mrs(BA_SECOND, 15'h02c4);
    chk_val({26'h0, rttnom, wlev, rttwr}, 32'h3c);
    ctl_u.cmd(4'h4, 3'h0, 15'h0);
    lat(1, n);
    @(posedge MCLK);
    #1;
    chk_bit(odt_wr, 1'h0);
    ctl_u.mrs(BA_SECOND, 15'h0);
    ctl_u.mrs(BA_FOURTH, 15'h0003);
    chk_val({29'h0, rd_pat, pat_sel}, 32'h0);
    ctl_u.mrs(BA_FOURTH, 15'h0006);
    chk_val({29'h0, rd_pat, pat_sel}, 32'h6);
    ctl_u.mrs(BA_FOURTH, 15'h0);
    ctl_u.mrs(BA_THIRD, 15'h0080);
    chk_bit(sr_ext, 1'h1);
    ctl_u.mrs(BA_THIRD, 15'h00c0);
    repeat (4) @(posedge MCLK);
    chk_bit(sr_ext, 1'h0);
    temp_hot <= 1'h1;
    repeat (5) @(posedge MCLK);
    chk_bit(sr_ext, 1'h1);
    temp_hot <= 1'h0;
    ctl_u.mrs(BA_THIRD, 15'h0003);
    chk_val({29'h0, ret_rng}, 32'h3);
    chk_bit(ret_lim, 1'h0);
    ctl_u.sr(1'h1);
    #1;
    chk_val({30'h0, self_ref, ret_lim}, 32'h3);
    ctl_u.cmd(4'h0, BA_THIRD, 15'h0);
    chk_val({29'h0, ret_rng}, 32'h3);
    ctl_u.sr(1'h0);
    repeat (2) @(posedge MCLK);
    chk_bit(self_ref, 1'h0);
    ctl_u.mrs(BA_SECOND, 15'h0001);
    chk_bit(dll_dis, 1'h1);
    ctl_u.mrs(BA_THIRD, 15'h0);
    rd_chk(OFS_MR_THIRD, 32'h8, RESP_OKAY);
    ctl_u.cmd(4'h5, 3'h0, 15'h0);
    lat(0, n);
    chk_lat(n, 5);
    ctl_u.mrs(BA_SECOND, 15'h0);
    chk_bit(dll_dis, 1'h0);
    axi_wr(OFS_CTRL, 32'h7, r);
    chk_val({30'h0, r}, {30'h0, RESP_OKAY});
    ctl_u.cmd(4'h5, 3'h0, 15'h0);
    lat(0, n);
    chk_lat(n, 7);
    axi_wr(OFS_MR_SECOND, 32'h1, r);
    chk_val({30'h0, r}, {30'h0, RESP_SLVERR});
    rd_chk(OFS_MR_SECOND, 32'h0, RESP_OKAY);
    axi_wr(8'h40, 32'h1, r);
    chk_val({30'h0, r}, {30'h0, RESP_DECERR});
    rd_chk(8'h40, 32'h0, RESP_DECERR);
    report_and_stop();
  end
endmodule : dram_mode_register_behaviour_tb
